/* File: logic/qds_defs.svh */
`ifndef QDS_DEFS_SVH
`define QDS_DEFS_SVH

// array shape (x18 variant: two 9-bit lanes)
`define QDS_AW 4
`define QDS_DW 18
`define QDS_LANES 2
`define QDS_LW 9
`define QDS_BEATS 4
`define QDS_WORDS 16

// register map, byte addresses
`define QDS_REG_CTRL 8'h00
`define QDS_REG_STAT 8'h04

// reset values
`define QDS_DRIVE_RESET 6'h20
`define QDS_TARGET_RESET 6'h20

// status field positions
`define QDS_ST_ECC 0
`define QDS_ST_TERM 1
`define QDS_ST_DRV_LO 8
`define QDS_ST_LVL_LO 16

// timing counts in clock cycles, FIFO depth and limit in entries
`define QDS_EVAL_CYCLES 10'h3FF
`define QDS_W_OFS 1
`define QDS_R_OFS 3
`define QDS_FIFO_DEPTH 16
`define QDS_FIFO_LIMIT 5'h0E

`endif

/* File: logic/qds_pkg.sv */
`default_nettype none
`include "qds_defs.svh"

package qds_pkg;

    // command loaded at a primary edge
    typedef enum logic [1:0]
    {
        QDS_DESEL = 2'b00,
        QDS_READ = 2'b01,
        QDS_WRITE = 2'b10
    } qds_cmd_t;

    // one complete write burst on its way to the array
    typedef struct packed
    {
        logic [`QDS_AW-1:0] addr;
        logic [`QDS_BEATS-1:0][`QDS_DW-1:0] data;
        logic [`QDS_BEATS-1:0][`QDS_LANES-1:0] mask_n;
    } qds_wr_entry_t;

endpackage

`default_nettype wire

/* File: logic/qds_fifo.sv */
`timescale 1ns/1ns
`default_nettype none

module qds_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic in_valid, // source offers a word
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // word offered
    output logic out_valid, // a word is waiting
    input wire logic out_ready, // drain takes the word
    output logic [WIDTH-1:0] out_data, // oldest word
    output logic [$clog2(DEPTH):0] level // words held
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic push;
    logic pop;

    // honest flags straight from the fill level
    assign in_ready = (level != DEPTH[PW:0]);
    assign out_valid = (level != '0);
    assign out_data = store[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage has no reset, only the pointers matter
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            store[wr_ptr] <= in_data;
        end
    end

    // pointers wrap naturally, depth is a power of two
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                level <= level + 1'b1;
            end
            else if (pop && !push)
            begin
                level <= level - 1'b1;
            end
        end
    end

endmodule // qds_fifo

`default_nettype wire

/* File: logic/qds_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "qds_defs.svh"

module qds_port (
    input wire logic clock, // system clock, 20 MHz
    input wire logic reset_n, // async reset, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // bus write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // bus acknowledge
    input wire logic [`QDS_AW-1:0] sync_addr_in, // burst address
    input wire logic read_sel_n, // read select, low active
    input wire logic write_sel_n, // write select, low active
    input wire logic [`QDS_DW-1:0] wr_data, // write beat
    input wire logic [`QDS_LANES-1:0] lane_write_mask_n, // per-lane mask
    input wire logic input_termination_select, // termination pin
    output logic [`QDS_DW-1:0] read_data, // read beat
    output logic read_data_oe, // read outputs driven
    output logic [5:0] drive_code, // output drive setting
    output logic term_active, // input termination on
    output logic ecc_active // error correction on
);
    import qds_pkg::*;

    logic ph;
    logic prim;
    qds_pkg::qds_cmd_t next_cmd;
    qds_pkg::qds_cmd_t last_cmd;
    logic [4:0] w_sr;
    logic [6:0] r_sr;
    logic [`QDS_AW-1:0] w_addr;
    qds_pkg::qds_wr_entry_t w_buf;
    qds_pkg::qds_wr_entry_t push_word;
    qds_pkg::qds_wr_entry_t drain_word;
    logic push_valid;
    logic push_ready;
    logic drain_valid;
    logic drain_ready;
    logic [4:0] fifo_level;
    logic wr_room;
    logic half_write;
    logic [`QDS_LW-1:0] rd_lane [`QDS_LANES][`QDS_BEATS];
    logic [`QDS_BEATS-1:0][`QDS_DW-1:0] rd_fetch;
    logic [`QDS_BEATS-1:0][`QDS_DW-1:0] rd_buf;
    logic [`QDS_BEATS-1:0][`QDS_DW-1:0] rd_out;
    logic [9:0] eval_cnt;
    logic eval_tick;
    logic [5:0] drive_target;
    logic bus_hit;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // half-rate phase: primary edge when low, complementary when high
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ph <= 1'b0;
        end
        else
        begin
            ph <= ~ph;
        end
    end
    assign prim = !ph;

    // two bursts may be in flight, so keep two slots spare
    assign wr_room = (fifo_level <= `QDS_FIFO_LIMIT);

    // command decode; read wins when both are low, unless the last loaded command was a read
    always_comb
    begin
        next_cmd = QDS_DESEL;
        if (prim)
        begin
            if (!read_sel_n && last_cmd != QDS_READ)
            begin
                next_cmd = QDS_READ;
            end
            else if (!write_sel_n && last_cmd != QDS_WRITE && wr_room)
            begin
                next_cmd = QDS_WRITE;
            end
        end
    end

    // last loaded command, updated only on primary edges
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            last_cmd <= QDS_DESEL;
        end
        else if (prim)
        begin
            last_cmd <= next_cmd;
        end
    end

    // beat shifters; separate bits let bursts overlap
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            w_sr <= '0;
            r_sr <= '0;
        end
        else
        begin
            w_sr <= {w_sr[3:0], next_cmd == QDS_WRITE};
            r_sr <= {r_sr[5:0], next_cmd == QDS_READ};
        end
    end

    // write capture; address moves to the burst at its first beat
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            w_addr <= '0;
            w_buf <= '0;
        end
        else
        begin
            if (next_cmd == QDS_WRITE)
            begin
                w_addr <= sync_addr_in;
            end
            if (w_sr[`QDS_W_OFS])
            begin
                w_buf.addr <= w_addr;
            end
            for (int b = 0; b < `QDS_BEATS; b++)
            begin
                if (w_sr[b + `QDS_W_OFS])
                begin
                    w_buf.data[b] <= wr_data;
                    w_buf.mask_n[b] <= lane_write_mask_n;
                end
            end
        end
    end

    // last beat joins the buffered three straight into the queue
    always_comb
    begin
        push_word = w_buf;
        push_word.data[3] = wr_data;
        push_word.mask_n[3] = lane_write_mask_n;
    end
    assign push_valid = w_sr[4];

    // a pair whose two masks differ is a half write
    assign half_write = (w_sr[2] && (w_buf.mask_n[0] != lane_write_mask_n))
        || (w_sr[4] && (w_buf.mask_n[2] != lane_write_mask_n));

    // sticky: only reset_n brings correction back
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ecc_active <= 1'b1;
        end
        else if (half_write)
        begin
            ecc_active <= 1'b0;
        end
    end

    // the array is single ported: a read fetch stalls the drain
    assign drain_ready = (next_cmd != QDS_READ);

    qds_fifo #(
        .WIDTH($bits(qds_pkg::qds_wr_entry_t)),
        .DEPTH(`QDS_FIFO_DEPTH)
    ) u_wr_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_word),
        .level(fifo_level)
    );

    // one storage slice per lane, each beat gated by its own mask
    for (genvar l = 0; l < `QDS_LANES; l++)
    begin : g_lane
        logic [`QDS_BEATS-1:0][`QDS_LW-1:0] lane_mem [`QDS_WORDS];

        always_ff @(posedge clock)
        begin
            if (drain_valid && drain_ready)
            begin
                for (int b = 0; b < `QDS_BEATS; b++)
                begin
                    if (!drain_word.mask_n[b][l])
                    begin
                        lane_mem[drain_word.addr][b] <= drain_word.data[b][l*`QDS_LW +: `QDS_LW];
                    end
                end
            end
        end

        for (genvar b = 0; b < `QDS_BEATS; b++)
        begin : g_beat
            assign rd_lane[l][b] = lane_mem[sync_addr_in][b];
        end
    end

    // lanes back into full beats
    always_comb
    begin
        rd_fetch = '0;
        for (int b = 0; b < `QDS_BEATS; b++)
        begin
            for (int l = 0; l < `QDS_LANES; l++)
            begin
                rd_fetch[b][l*`QDS_LW +: `QDS_LW] = rd_lane[l][b];
            end
        end
    end

    // fetch at the command, hand over one edge before the first beat
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_buf <= '0;
            rd_out <= '0;
        end
        else
        begin
            if (next_cmd == QDS_READ)
            begin
                rd_buf <= rd_fetch;
            end
            if (r_sr[2])
            begin
                rd_out <= rd_buf;
            end
        end
    end

    // read beats; idle slots float or go low per termination
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_data <= '0;
            read_data_oe <= 1'b0;
        end
        else if (|r_sr[6:3])
        begin
            read_data_oe <= 1'b1;
            read_data <= r_sr[3] ? rd_out[0] : r_sr[4] ? rd_out[1] :
                r_sr[5] ? rd_out[2] : rd_out[3];
        end
        else
        begin
            read_data <= '0;
            read_data_oe <= term_active;
        end
    end

    // free-running evaluation counter
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            eval_cnt <= '0;
            eval_tick <= 1'b0;
        end
        else
        begin
            eval_tick <= (eval_cnt == `QDS_EVAL_CYCLES);
            eval_cnt <= (eval_cnt == `QDS_EVAL_CYCLES) ? '0 : eval_cnt + 1'b1;
        end
    end

    // single step per tick keeps the drivers from glitching
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            drive_code <= `QDS_DRIVE_RESET;
            term_active <= 1'b0;
        end
        else if (eval_tick)
        begin
            term_active <= input_termination_select;
            if (drive_code < drive_target)
            begin
                drive_code <= drive_code + 1'b1;
            end
            else if (drive_code > drive_target)
            begin
                drive_code <= drive_code - 1'b1;
            end
        end
    end

    // classic slave, answers one cycle after the strobe; a write lands on the
    // edge that the master sees ack on, so it never lands before the handshake
    assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            drive_target <= `QDS_TARGET_RESET;
        end
        else
        begin
            wb_ack_o <= bus_hit;
            wb_dat_o <= '0;
            if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `QDS_REG_CTRL
                && wb_sel_i[0])
            begin
                drive_target <= wb_dat_i[5:0];
            end
            if (bus_hit && !wb_we_i)
            begin
                case (wb_adr_i)
                    `QDS_REG_CTRL: wb_dat_o <= {26'h0000000, drive_target};
                    `QDS_REG_STAT:
                    begin
                        wb_dat_o[`QDS_ST_ECC] <= ecc_active;
                        wb_dat_o[`QDS_ST_TERM] <= term_active;
                        wb_dat_o[`QDS_ST_DRV_LO +: 6] <= drive_code;
                        wb_dat_o[`QDS_ST_LVL_LO +: 5] <= fifo_level;
                    end
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    sequence s_read_beats;
        read_data_oe && read_data == $past(rd_fetch[0], 5)
        ##1 read_data_oe && read_data == $past(rd_fetch[1], 6)
        ##1 read_data_oe && read_data == $past(rd_fetch[2], 7)
        ##1 read_data_oe && read_data == $past(rd_fetch[3], 8);
    endsequence

    sequence s_write_cmd;
        next_cmd == QDS_WRITE;
    endsequence

    a_read_beat_order: assert property (next_cmd == QDS_READ |-> ##5 s_read_beats)
        else $error("read beats wrong or late");
    a_write_beat_push: assert property (s_write_cmd |-> ##5 push_valid && push_ready
        && push_word.data[0] == $past(wr_data, 3) && push_word.data[3] == wr_data)
        else $error("write burst not queued as sampled");
    a_both_high_desel: assert property (read_sel_n && write_sel_n |-> next_cmd == QDS_DESEL)
        else $error("both selects high not a deselect");
    a_repeat_ignored: assert property (last_cmd != QDS_DESEL |-> next_cmd != last_cmd)
        else $error("repeated command accepted");
    a_ecc_stays_off: assert property (!ecc_active |=> !ecc_active)
        else $error("correction came back");
    a_half_kills_ecc: assert property (half_write |=> !ecc_active)
        else $error("half write left correction on");
    a_idle_out_level: assert property (!(|r_sr[6:3]) |=> read_data == '0
        && read_data_oe == $past(term_active))
        else $error("idle read outputs wrong");
    a_eval_one_step: assert property (eval_tick |=> drive_code == $past(drive_code)
        || drive_code == $past(drive_code) + 6'h01 || drive_code == $past(drive_code) - 6'h01)
        else $error("drive moved more than a step");
    a_eval_spacing: assert property (eval_tick |=> !eval_tick [*8])
        else $error("evaluation ticks too close");
    a_term_refresh: assert property (eval_tick |=> term_active == $past(input_termination_select)
        ##1 $stable(term_active))
        else $error("termination not refreshed on tick");

endmodule // qds_port

`default_nettype wire

/* File: bench/qds_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
`include "qds_defs.svh"

// memory controller on the far side of the burst port
module qds_ctrl_model (
    input wire logic clock, // system clock
    input wire logic reset_n, // async reset, active low
    output logic [`QDS_AW-1:0] sync_addr_in, // burst address
    output logic read_sel_n, // read select
    output logic write_sel_n, // write select
    output logic [`QDS_DW-1:0] wr_data, // write beat
    output logic [`QDS_LANES-1:0] lane_write_mask_n // lane masks
);
    logic ph;

    // own copy of the device phase; primary edges see ph low
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            ph <= 1'b0;
        else
            ph <= ~ph;
    end

    // quiet bus at time zero
    initial
    begin
        sync_addr_in = 4'h0;
        read_sel_n = 1'b1;
        write_sel_n = 1'b1;
        wr_data = 18'h00000;
        lane_write_mask_n = 2'h3;
    end

    // one command, placed so that a primary edge samples it
    task command(input logic rd, input logic wr, input logic [`QDS_AW-1:0] a);
        begin
            @(posedge clock);
            if (ph === 1'b0)
                @(posedge clock);
            sync_addr_in <= a;
            read_sel_n <= ~rd;
            write_sel_n <= ~wr;
            @(posedge clock);
            read_sel_n <= 1'b1;
            write_sel_n <= 1'b1;
            sync_addr_in <= ~a; // moves only between sampling edges
        end
    endtask

    // four beats after a write command; call right after its edge
    task beats(input logic [3:0][`QDS_DW-1:0] d, input logic [3:0][`QDS_LANES-1:0] m);
        begin
            @(posedge clock);
            for (int i = 0; i < 4; i++)
            begin
                wr_data <= d[i];
                lane_write_mask_n <= m[i];
                @(posedge clock);
            end
            // terminated inputs keep a firm level, never the last beat
            wr_data <= ~d[3];
            lane_write_mask_n <= 2'h3;
        end
    endtask
endmodule // qds_ctrl_model

`default_nettype wire

/* File: bench/quad_ddr_sram_port_bytemask_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "qds_defs.svh"

`define CHECK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module quad_ddr_sram_port_bytemask_test;
    localparam logic [3:0][17:0] D0 = {9'h103, 9'h003, 9'h102, 9'h002, 9'h101, 9'h001,
        9'h100, 9'h000};
    localparam logic [3:0][17:0] D2 = {9'h0C3, 9'h1C3, 9'h0C2, 9'h1C2, 9'h0C1, 9'h1C1,
        9'h0C0, 9'h1C0};
    localparam logic [3:0][17:0] E = {9'h0C3, 9'h003, 9'h0C2, 9'h002, 9'h101, 9'h1C1,
        9'h100, 9'h1C0};
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] sync_addr_in;
    logic read_sel_n;
    logic write_sel_n;
    logic [17:0] wr_data;
    logic [1:0] lane_write_mask_n;
    logic input_termination_select = 1'b0;
    logic [17:0] read_data;
    logic read_data_oe;
    logic [5:0] drive_code;
    logic term_active;
    logic ecc_active;
    logic [31:0] q;
    int miscompares = 0;
    int comparisons = 0;

    // 20 MHz
    always #25 clock = ~clock;

    qds_port uut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_addr_in(sync_addr_in),
        .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .wr_data(wr_data),
        .lane_write_mask_n(lane_write_mask_n),
        .input_termination_select(input_termination_select), .read_data(read_data),
        .read_data_oe(read_data_oe), .drive_code(drive_code), .term_active(term_active),
        .ecc_active(ecc_active));

    qds_ctrl_model ctrl (.clock(clock), .reset_n(reset_n), .sync_addr_in(sync_addr_in),
        .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .wr_data(wr_data),
        .lane_write_mask_n(lane_write_mask_n));

    task complete_run;
        begin
            $display("comparisons %0d miscompares %0d", comparisons, miscompares);
            if (miscompares == 0 && comparisons > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // classic wishbone cycle; waits for ack without assuming a latency
    task wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        begin
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= a;
            wb_dat_i <= d;
            wb_sel_i <= 4'hF;
            n = 0;
            @(posedge clock);
            while (wb_ack_o !== 1'b1 && n < 20)
            begin
                @(posedge clock);
                n++;
            end
            if (wb_ack_o !== 1'b1)
            begin
                miscompares++;
                complete_run;
            end
            r = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge clock);
        end
    endtask

    // read burst, beats sampled at the four edges the port drives them for
    task rd_burst(input logic [3:0] a, input logic [3:0][17:0] e);
        begin
            ctrl.command(1'b1, 1'b0, a);
            repeat (4) @(posedge clock);
            for (int i = 0; i < 4; i++)
            begin
                @(posedge clock);
                `CHECK(read_data_oe, 1'b1)
                `CHECK(read_data, e[i])
            end
        end
    endtask

    task wr_burst(input logic [3:0] a, input logic [3:0][17:0] d, input logic [7:0] m);
        begin
            ctrl.command(1'b0, 1'b1, a);
            ctrl.beats(d, m);
            repeat (10) @(posedge clock); // queued writes land first
        end
    endtask

    task s_reset;
        begin
            `CHECK(read_data_oe, 1'b0)
            `CHECK(read_data, 18'h00000)
            wb_cycle(1'b0, `QDS_REG_STAT, 32'h0, q);
            `CHECK(q, 32'h00002001)
            wb_cycle(1'b1, `QDS_REG_STAT, 32'hFFFFFFFF, q);
            wb_cycle(1'b0, `QDS_REG_STAT, 32'h0, q);
            `CHECK(q, 32'h00002001)
            wb_cycle(1'b0, `QDS_REG_CTRL, 32'h0, q);
            `CHECK(q, 32'h00000020)
            wb_cycle(1'b1, 8'h10, 32'h0000003F, q);
            wb_cycle(1'b0, 8'h10, 32'h0, q);
            `CHECK(q, 32'h00000000)
        end
    endtask

    // full writes and lane masks; a read overlaps the tail of a write
    task s_overlap;
        begin
            wr_burst(4'h1, D0, 8'h00);
            ctrl.command(1'b0, 1'b1, 4'h2);
            fork
                ctrl.beats(~D0, 8'h00);
                rd_burst(4'h1, D0);
            join
            repeat (10) @(posedge clock);
            wr_burst(4'h1, D2, 8'h5A);
            rd_burst(4'h1, E);
            rd_burst(4'h2, ~D0);
            `CHECK(ecc_active, 1'b1)
        end
    endtask

    // repeated commands of one kind are ignored
    task s_dup;
        begin
            ctrl.command(1'b1, 1'b0, 4'h1);
            ctrl.command(1'b1, 1'b0, 4'h1);
            repeat (7) @(posedge clock);
            `CHECK(read_data_oe, 1'b0)
            `CHECK(read_data, 18'h00000)
            ctrl.command(1'b0, 1'b1, 4'h3);
            fork
                ctrl.beats(D2, 8'h00);
                ctrl.command(1'b0, 1'b1, 4'h2);
            join
            repeat (10) @(posedge clock);
            rd_burst(4'h2, ~D0);
            rd_burst(4'h3, D2);
        end
    endtask

    task s_half;
        begin
            wr_burst(4'h5, D2, 8'h04);
            `CHECK(ecc_active, 1'b0)
            wr_burst(4'h6, D0, 8'h00);
            rd_burst(4'h6, D0);
            `CHECK(ecc_active, 1'b0)
        end
    endtask

    // drive code walks to the target one step per evaluation tick
    task s_term;
        int n;
        int last;
        int steps;
        logic [5:0] code;
        begin
            `CHECK(term_active, 1'b0)
            input_termination_select <= 1'b1;
            wb_cycle(1'b1, `QDS_REG_CTRL, 32'h00000022, q);
            code = drive_code;
            n = 0;
            last = 0;
            steps = 0;
            while (steps < 2 && n < 2200)
            begin
                @(posedge clock);
                n++;
                if (drive_code !== code)
                begin
                    `CHECK(drive_code, code + 6'h01)
                    if (steps > 0)
                        `CHECK(n - last, 1024)
                    last = n;
                    steps++;
                    code = drive_code;
                end
            end
            if (steps < 2)
            begin
                miscompares++;
                complete_run;
            end
            `CHECK(term_active, 1'b1)
            `CHECK(read_data_oe, 1'b1)
            `CHECK(read_data, 18'h00000)
            wb_cycle(1'b0, `QDS_REG_STAT, 32'h0, q);
            `CHECK(q, 32'h00002202)
        end
    endtask

    // reset for 16 cycles, then the scenarios in turn
    initial
    begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        s_reset;
        s_overlap;
        s_dup;
        s_half;
        s_term;
        complete_run;
    end
endmodule // quad_ddr_sram_port_bytemask_test

`default_nettype wire
